/* File: rcs_map.svh */
/*
 * Offsets, field positions, reset values, codes and timing counts of the
 * remote command serializer.
 * Assumes a 100 MHz system clock and 32-bit AXI4-Lite register access.
 */
`ifndef RCS_MAP_SVH
`define RCS_MAP_SVH

// register byte offsets
`define RCS_CTRL_OFS 12'h000
`define RCS_STATUS_OFS 12'h004
`define RCS_CHAN_OFS 12'h008
`define RCS_FRAMES_OFS 12'h00C

// control fields and reset value
`define RCS_CTRL_EN_BIT 0
`define RCS_CTRL_TRIG_BIT 1
`define RCS_CTRL_RESET 1'b1

// channel bit positions, also the multiplexer address of each channel
`define RCS_CH_FUNC_LO 0
`define RCS_CH_FUNC_HI 1
`define RCS_CH_FILTER 2
`define RCS_CH_EXTREF 3
`define RCS_CH_AUTO 4
`define RCS_CH_RANGE_LO 5
`define RCS_CH_RANGE_HI 7

// function codes {upper, low}
`define RCS_FUNC_DC 2'h0
`define RCS_FUNC_AC 2'h1
`define RCS_FUNC_KOHM 2'h2
`define RCS_FUNC_LOHM 2'h3

// range codes {top, mid, low, auto}
`define RCS_RNG_AUTO 4'hE
`define RCS_RNG_10K 4'h1
`define RCS_RNG_1K 4'h3
`define RCS_RNG_100 4'h5
`define RCS_RNG_10 4'h7
`define RCS_RNG_1 4'h9
`define RCS_RNG_0P1 4'hB

// timing
`define RCS_CLK_HZ 100000000
`define RCS_CLK_NS 10
`define RCS_GATED_OSC_HZ 500000
`define RCS_STEP_CYC (`RCS_CLK_HZ / `RCS_GATED_OSC_HZ)
`define RCS_SLOT_NS 1000
`define RCS_SLOT_CYC (`RCS_SLOT_NS / `RCS_CLK_NS)
`define RCS_SAMPLE_HZ 2000
`define RCS_SAMPLE_CYC (`RCS_CLK_HZ / `RCS_SAMPLE_HZ)

`endif

/* File: rcs_pkg.sv */
/*
 * Types of the remote command serializer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rcs_pkg;
    // sequence counter states, coded as the counter values themselves
    typedef enum logic [3:0] {
        SEQ_IDLE = 4'b0000,
        SEQ_S8 = 4'b1000,
        SEQ_S9 = 4'b1001,
        SEQ_S11 = 4'b1011,
        SEQ_S10 = 4'b1010,
        SEQ_S12 = 4'b1100,
        SEQ_S13 = 4'b1101,
        SEQ_S14 = 4'b1110,
        SEQ_S15 = 4'b1111
    } rcs_seq_t;
    // axi response codes
    typedef enum logic [1:0] {
        RESP_OKAY = 2'b00,
        RESP_SLVERR = 2'b10
    } rcs_resp_t;
endpackage

/* File: rcs_remote_command_serializer.sv */
/*
 * Remote command serializer: command coding with interlock, sample pulse
 * generation, eight-slot serializer, shift-register receiver, output latch,
 * decoder and an AXI4-Lite register slave.
 * Assumes asynchronous command and trigger pins (synchronised here), one
 * 100 MHz clock and a synchronous active-low reset.
 */
// Summary of operation
// - twelve command lines coded into eight channels
// - active-low function selects give two-bit code
// - active-low range selects give four-bit code
// - disallowed range and function pairs are rejected
// - only one function ever takes effect
// - sample pulse presets counter to 1000
// - gated oscillator steps counter at 500 kHz
// - state zero stops counting until next pulse
// - counter state addresses one channel bit
// - receiver restores, buffers and decodes eight bits
// - continuous mode samples at 2 kHz
// - inhibit low plus trigger pulse gives one cycle
// - eight slots, one bit each, 1 us long
// - latch holds during loading, updates after
`include "rcs_map.svh"

module rcs_remote_command_serializer #(
    parameter int unsigned SAMPLE_CYC = `RCS_SAMPLE_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    // command pins, active low
    input wire logic dcVoltSelect_b,
    input wire logic acVoltSelect_b,
    input wire logic kiloResistSelect_b,
    input wire logic lowOhmsSelect_b,
    input wire logic range10kSelect_b,
    input wire logic range1kSelect_b,
    input wire logic range100Select_b,
    input wire logic range10Select_b,
    input wire logic range1Select_b,
    input wire logic range0p1Select_b,
    input wire logic filterSelect_b,
    input wire logic extRefSelect_b,
    input wire logic commandTriggerIn,
    input wire logic freeRunInhibit,
    // serial stream, observable
    output logic serialData,
    output logic serialSlot,
    // decoded instrument controls
    output logic dcVoltOut,
    output logic acVoltOut,
    output logic kiloResistOut,
    output logic lowOhmsOut,
    output logic filterOut,
    output logic extRefOut,
    output logic autoRangeOut,
    output logic [2:0] rangeCodeOut,
    // axi4-lite slave
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output rcs_pkg::rcs_resp_t s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output rcs_pkg::rcs_resp_t s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import rcs_pkg::*;

    localparam int unsigned STEP_CYC = `RCS_STEP_CYC;
    localparam int unsigned SLOT_CYC = `RCS_SLOT_CYC;

    // interlocked coder: function first, then range checked against it
    function automatic logic [7:0] codeChannels(input logic [11:0] c);
        logic [1:0] fn;
        logic [3:0] rg;
        fn = `RCS_FUNC_DC;
        rg = `RCS_RNG_AUTO;
        // priority makes incompatible functions impossible together
        if (!c[3]) fn = `RCS_FUNC_LOHM;
        else if (!c[2]) fn = `RCS_FUNC_KOHM;
        else if (!c[1]) fn = `RCS_FUNC_AC;
        // a range not allowed with the function is passed over for the next selected range, else autorange
        if (!c[4] && fn[1]) rg = `RCS_RNG_10K;
        else if (!c[5]) rg = `RCS_RNG_1K;
        else if (!c[6]) rg = `RCS_RNG_100;
        else if (!c[7] && fn != `RCS_FUNC_KOHM) rg = `RCS_RNG_10;
        else if (!c[8] && !fn[1]) rg = `RCS_RNG_1;
        else if (!c[9] && fn == `RCS_FUNC_DC) rg = `RCS_RNG_0P1;
        return {rg, !c[11], !c[10], fn};
    endfunction

    // 3-stage synchronisers; first stage feeds only the second
    logic [13:0] pinsRaw;
    logic [13:0] syncA_q, syncB_q, syncC_q, pinFilt_q;
    logic [13:0] syncA_d, syncB_d, syncC_d, pinFilt_d;
    logic trigPrev_q, trigPrev_d;
    assign pinsRaw = {freeRunInhibit, commandTriggerIn, extRefSelect_b, filterSelect_b,
        range0p1Select_b, range1Select_b, range10Select_b, range100Select_b,
        range1kSelect_b, range10kSelect_b, lowOhmsSelect_b, kiloResistSelect_b,
        acVoltSelect_b, dcVoltSelect_b};

    always_comb begin
        syncA_d = pinsRaw;
        syncB_d = syncA_q;
        syncC_d = syncB_q;
        pinFilt_d = pinFilt_q;
        trigPrev_d = pinFilt_q[12];
        // a change counts once the second and third stages agree
        for (int i = 0; i < 14; i++) begin
            if (syncB_q[i] == syncC_q[i]) pinFilt_d[i] = syncC_q[i];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            syncA_q <= 14'h3FFF;
            syncB_q <= 14'h3FFF;
            syncC_q <= 14'h3FFF;
            pinFilt_q <= 14'h3FFF;
            trigPrev_q <= 1'b1;
        end else begin
            syncA_q <= syncA_d;
            syncB_q <= syncB_d;
            syncC_q <= syncC_d;
            pinFilt_q <= pinFilt_d;
            trigPrev_q <= trigPrev_d;
        end
    end

    logic trigF, inhF, contMode, extTrigEdge;
    logic [7:0] chanNow;
    assign trigF = pinFilt_q[12];
    assign inhF = pinFilt_q[13];
    assign contMode = trigF && inhF;
    assign extTrigEdge = !inhF && trigF && !trigPrev_q;
    assign chanNow = codeChannels(pinFilt_q[11:0]);

    // sample oscillator: free runs in continuous mode only
    logic [15:0] sampleCnt_q, sampleCnt_d;
    logic ctrlEn_q, swTrig_q;
    logic samplePulse;
    always_comb begin
        sampleCnt_d = 16'h0000;
        samplePulse = 1'b0;
        if (contMode && ctrlEn_q) begin
            if (sampleCnt_q == 16'(SAMPLE_CYC - 1)) begin
                samplePulse = 1'b1;
            end else begin
                sampleCnt_d = sampleCnt_q + 16'h0001;
            end
        end
        if (ctrlEn_q && extTrigEdge) samplePulse = 1'b1;
        if (swTrig_q) samplePulse = 1'b1;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) sampleCnt_q <= 16'h0000;
        else sampleCnt_q <= sampleCnt_d;
    end

    // sequence counter, gated oscillator, serializer and receiver
    rcs_seq_t seq_q, seq_d;
    logic [7:0] stepCnt_q, stepCnt_d;
    logic [7:0] frame_q, frame_d; // channels frozen for one frame
    logic [7:0] shiftReg_q, shiftReg_d;
    logic [7:0] latch_q, latch_d;
    logic [31:0] frames_q, frames_d;
    logic serData_d, serSlot_d;
    logic [9:0] decOut_q, decOut_d;
    logic busy;
    assign busy = (seq_q != SEQ_IDLE);

    always_comb begin
        seq_d = seq_q;
        stepCnt_d = stepCnt_q;
        frame_d = frame_q;
        shiftReg_d = shiftReg_q;
        latch_d = latch_q;
        frames_d = frames_q;
        decOut_d = decOut_q;
        serData_d = 1'b0;
        serSlot_d = 1'b0;
        if (!busy) begin
            // a pulse that lands while busy is simply dropped
            if (samplePulse) begin
                seq_d = SEQ_S8;
                stepCnt_d = 8'h00;
                frame_d = chanNow;
            end
        end else begin
            // one gated-oscillator period per counter state
            if (stepCnt_q == 8'(STEP_CYC - 1)) begin
                stepCnt_d = 8'h00;
                unique case (seq_q)
                    SEQ_S8: seq_d = SEQ_S9;
                    SEQ_S9: seq_d = SEQ_S11;
                    SEQ_S11: seq_d = SEQ_S10;
                    SEQ_S10: seq_d = SEQ_S12;
                    SEQ_S12: seq_d = SEQ_S13;
                    SEQ_S13: seq_d = SEQ_S14;
                    SEQ_S14: seq_d = SEQ_S15;
                    SEQ_S15: seq_d = SEQ_IDLE;
                    default: seq_d = SEQ_IDLE;
                endcase
            end else begin
                stepCnt_d = stepCnt_q + 8'h01;
            end
            // low three counter bits address the multiplexer
            serData_d = frame_q[seq_q[2:0]];
            serSlot_d = (stepCnt_q < 8'(SLOT_CYC));
            // receiver shifts each bit in at the start of its slot
            if (stepCnt_q == 8'h00) shiftReg_d = {frame_q[seq_q[2:0]], shiftReg_q[7:1]};
            // latch follows once loading ends; slots 2 and 3 come in swapped
            if (seq_d == SEQ_IDLE) begin
                latch_d = {shiftReg_q[7:4], shiftReg_q[2], shiftReg_q[3], shiftReg_q[1:0]};
                frames_d = frames_q + 32'h0000_0001;
            end
        end
        // decoder: back to one line per function, plus range and options
        decOut_d[0] = (latch_d[1:0] == `RCS_FUNC_DC);
        decOut_d[1] = (latch_d[1:0] == `RCS_FUNC_AC);
        decOut_d[2] = (latch_d[1:0] == `RCS_FUNC_KOHM);
        decOut_d[3] = (latch_d[1:0] == `RCS_FUNC_LOHM);
        decOut_d[4] = latch_d[`RCS_CH_FILTER];
        // external reference locked out in both resistance functions
        decOut_d[5] = latch_d[`RCS_CH_EXTREF] && !latch_d[`RCS_CH_FUNC_HI];
        decOut_d[6] = !latch_d[`RCS_CH_AUTO];
        decOut_d[9:7] = latch_d[`RCS_CH_RANGE_HI:`RCS_CH_RANGE_LO];
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            seq_q <= SEQ_IDLE;
            stepCnt_q <= 8'h00;
            frame_q <= 8'h00;
            shiftReg_q <= 8'h00;
            latch_q <= 8'h00;
            frames_q <= 32'h0000_0000;
            serialData <= 1'b0;
            serialSlot <= 1'b0;
            decOut_q <= 10'h041;
        end else begin
            seq_q <= seq_d;
            stepCnt_q <= stepCnt_d;
            frame_q <= frame_d;
            shiftReg_q <= shiftReg_d;
            latch_q <= latch_d;
            frames_q <= frames_d;
            serialData <= serData_d;
            serialSlot <= serSlot_d;
            decOut_q <= decOut_d;
        end
    end

    assign {rangeCodeOut, autoRangeOut, extRefOut, filterOut, lowOhmsOut, kiloResistOut,
        acVoltOut, dcVoltOut} = decOut_q;

    // axi4-lite slave: address and data taken in either order
    logic awHeld_q, awHeld_d, wHeld_q, wHeld_d;
    logic [11:0] awAddr_q, awAddr_d;
    logic [31:0] wData_q, wData_d;
    logic [3:0] wStrb_q, wStrb_d;
    logic bValid_d, arReady_d, rValid_d, awReady_d, wReady_d;
    rcs_resp_t bResp_d, rResp_d;
    logic [31:0] rData_d;
    logic ctrlEn_d, swTrig_d;

    always_comb begin
        awHeld_d = awHeld_q;
        wHeld_d = wHeld_q;
        awAddr_d = awAddr_q;
        wData_d = wData_q;
        wStrb_d = wStrb_q;
        bValid_d = s_axi_bvalid;
        bResp_d = s_axi_bresp;
        rValid_d = s_axi_rvalid;
        rResp_d = s_axi_rresp;
        rData_d = s_axi_rdata;
        ctrlEn_d = ctrlEn_q;
        swTrig_d = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            awHeld_d = 1'b1;
            awAddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wHeld_d = 1'b1;
            wData_d = s_axi_wdata;
            wStrb_d = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) bValid_d = 1'b0;
        // perform the write once both halves are held
        if (awHeld_q && wHeld_q && !s_axi_bvalid) begin
            awHeld_d = 1'b0;
            wHeld_d = 1'b0;
            bValid_d = 1'b1;
            bResp_d = RESP_SLVERR;
            if (awAddr_q[11:2] == 10'(`RCS_CTRL_OFS >> 2)) begin
                bResp_d = RESP_OKAY;
                if (wStrb_q[0]) begin
                    ctrlEn_d = wData_q[`RCS_CTRL_EN_BIT];
                    swTrig_d = wData_q[`RCS_CTRL_TRIG_BIT];
                end
            end else if (awAddr_q[11:2] == 10'(`RCS_STATUS_OFS >> 2) ||
                awAddr_q[11:2] == 10'(`RCS_CHAN_OFS >> 2) ||
                awAddr_q[11:2] == 10'(`RCS_FRAMES_OFS >> 2)) begin
                bResp_d = RESP_OKAY; // read-only, write ignored
            end
        end
        awReady_d = !awHeld_d;
        wReady_d = !wHeld_d;
        if (s_axi_rvalid && s_axi_rready) rValid_d = 1'b0;
        if (s_axi_arvalid && s_axi_arready) begin
            rValid_d = 1'b1;
            rResp_d = RESP_OKAY;
            rData_d = 32'h0000_0000;
            unique case (s_axi_araddr[11:2])
                10'(`RCS_CTRL_OFS >> 2): rData_d[0] = ctrlEn_q;
                10'(`RCS_STATUS_OFS >> 2): rData_d[6:0] = {contMode, !inhF, busy, seq_q};
                10'(`RCS_CHAN_OFS >> 2): rData_d[15:0] = {chanNow, latch_q};
                10'(`RCS_FRAMES_OFS >> 2): rData_d = frames_q;
                default: rResp_d = RESP_SLVERR;
            endcase
        end
        arReady_d = !rValid_d;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= 12'h000;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            ctrlEn_q <= `RCS_CTRL_RESET;
            swTrig_q <= 1'b0;
        end else begin
            awHeld_q <= awHeld_d;
            wHeld_q <= wHeld_d;
            awAddr_q <= awAddr_d;
            wData_q <= wData_d;
            wStrb_q <= wStrb_d;
            s_axi_awready <= awReady_d;
            s_axi_wready <= wReady_d;
            s_axi_bvalid <= bValid_d;
            s_axi_bresp <= bResp_d;
            s_axi_arready <= arReady_d;
            s_axi_rvalid <= rValid_d;
            s_axi_rresp <= rResp_d;
            s_axi_rdata <= rData_d;
            ctrlEn_q <= ctrlEn_d;
            swTrig_q <= swTrig_d;
        end
    end

endmodule // rcs_remote_command_serializer

/* File: rcs_controller_model.sv */
/* far-side controller model: drives the command pins and the trigger line.
   assumes the bench states its selections as active-high wishes. */
module rcs_controller_model (
    input wire logic clk,
    input wire logic [11:0] cmdReq,
    input wire logic freeRun,
    input wire logic trigReq,
    output logic [11:0] cmdPins_b,
    output logic commandTriggerIn,
    output logic freeRunInhibit
);
    logic [4:0] lowCnt; // cycles left of the low trigger pulse
    // a wish is a contact closure, so its line goes low
    assign cmdPins_b = ~cmdReq;
    // continuous mode keeps inhibit high, triggered mode holds it low
    assign freeRunInhibit = freeRun;
    // a trigger is a 20-cycle low pulse; the line idles high like an open pin
    initial lowCnt = 5'h00;
    always @(posedge clk) begin
        if (trigReq) lowCnt <= 5'h14;
        else if (lowCnt != 5'h00) lowCnt <= lowCnt - 5'h01;
    end
    assign commandTriggerIn = (lowCnt == 5'h00);
endmodule // rcs_controller_model

/* File: rcs_serializer_checker.sv */
/* port checker of the serializer: slot timing, decoded outputs, bus holds.
   assumes binding to the top module with one clock and rst_b. */
module rcs_serializer_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic serialSlot,
    input wire logic dcVoltOut,
    input wire logic acVoltOut,
    input wire logic kiloResistOut,
    input wire logic lowOhmsOut,
    input wire logic filterOut,
    input wire logic extRefOut,
    input wire logic autoRangeOut,
    input wire logic [2:0] rangeCodeOut,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire rcs_pkg::rcs_resp_t s_axi_bresp
);
    import rcs_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [10:0] hiCnt_q, hiCnt_d; // cycles the slot strobe has been high
    logic [10:0] loCnt_q, loCnt_d; // cycles it has been low, saturating
    // counters saturate so a long idle gap cannot wrap into a false match
    always_comb begin
        hiCnt_d = !serialSlot ? 11'h000 : hiCnt_q + {10'h000, hiCnt_q != 11'h7FF};
        loCnt_d = serialSlot ? 11'h000 : loCnt_q + {10'h000, loCnt_q != 11'h7FF};
    end
    // registers only
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hiCnt_q <= 11'h000;
            loCnt_q <= 11'h7FF;
        end else begin
            hiCnt_q <= hiCnt_d;
            loCnt_q <= loCnt_d;
        end
    end
    sequence slotEnds;
        $fell(serialSlot);
    endsequence
    sequence nextSlotInFrame;
        $rose(serialSlot) && loCnt_q < 11'h0C8;
    endsequence
    chk_slot_width: assert property (slotEnds |-> hiCnt_q == 11'h064)
        else $error("slot strobe not 100 cycles");
    chk_slot_step: assert property (nextSlotInFrame |-> loCnt_q == 11'h064)
        else $error("slot spacing not 200 cycles");
    chk_one_function: assert property
        ($onehot({dcVoltOut, acVoltOut, kiloResistOut, lowOhmsOut}))
        else $error("function outputs not one-hot");
    chk_extref_lock: assert property ((kiloResistOut || lowOhmsOut) |-> !extRefOut)
        else $error("external reference in resistance function");
    chk_latch_hold: assert property ($changed({dcVoltOut, acVoltOut, kiloResistOut,
        lowOhmsOut, filterOut, extRefOut, autoRangeOut, rangeCodeOut})
        |-> !serialSlot && !$past(serialSlot))
        else $error("outputs changed while loading");
    chk_tenk_range: assert property
        ((dcVoltOut || acVoltOut) |-> !(rangeCodeOut == 3'h0 && !autoRangeOut))
        else $error("10k range with a voltage function");
    chk_tenth_range: assert property
        (!dcVoltOut |-> !(rangeCodeOut == 3'h5 && !autoRangeOut))
        else $error("0.1 range without dc volts");
    chk_read_hold: assert property
        (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_write_hold: assert property
        (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
endmodule // rcs_serializer_checker

bind rcs_remote_command_serializer rcs_serializer_checker chk (.clk, .rst_b, .serialSlot,
    .dcVoltOut, .acVoltOut, .kiloResistOut, .lowOhmsOut, .filterOut, .extRefOut,
    .autoRangeOut, .rangeCodeOut, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp);

/* File: rcs_remote_command_serializer_tb.sv */
/* self-checking bench: command coding, serial frame, triggered mode, registers.
   assumes the controller model and a 100 MHz clock; sample period shortened. */
`include "rcs_map.svh"
module rcs_remote_command_serializer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rcs_pkg::*;
    logic clk, rst_b, freeRun, trigReq, serialData, serialSlot;
    logic [11:0] cmdReq, cmdPins_b, awaddr, araddr;
    logic commandTriggerIn, freeRunInhibit, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, dcVoltOut, acVoltOut, kiloResistOut, lowOhmsOut;
    logic filterOut, extRefOut, autoRangeOut;
    logic [2:0] rangeCodeOut;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    rcs_resp_t bresp, rresp;
    int miscompares = 0;
    int testsRun = 0;
    rcs_controller_model ctl (.clk(clk), .cmdReq(cmdReq), .freeRun(freeRun),
        .trigReq(trigReq), .cmdPins_b(cmdPins_b), .commandTriggerIn(commandTriggerIn),
        .freeRunInhibit(freeRunInhibit));
    // 2000-cycle sample period leaves idle time after each 1600-cycle frame
    rcs_remote_command_serializer #(.SAMPLE_CYC(2000)) uut (.clk(clk), .rst_b(rst_b),
        .dcVoltSelect_b(cmdPins_b[0]), .acVoltSelect_b(cmdPins_b[1]),
        .kiloResistSelect_b(cmdPins_b[2]), .lowOhmsSelect_b(cmdPins_b[3]),
        .range10kSelect_b(cmdPins_b[4]), .range1kSelect_b(cmdPins_b[5]),
        .range100Select_b(cmdPins_b[6]), .range10Select_b(cmdPins_b[7]),
        .range1Select_b(cmdPins_b[8]), .range0p1Select_b(cmdPins_b[9]),
        .filterSelect_b(cmdPins_b[10]), .extRefSelect_b(cmdPins_b[11]),
        .commandTriggerIn(commandTriggerIn), .freeRunInhibit(freeRunInhibit),
        .serialData(serialData), .serialSlot(serialSlot), .dcVoltOut(dcVoltOut),
        .acVoltOut(acVoltOut), .kiloResistOut(kiloResistOut), .lowOhmsOut(lowOhmsOut),
        .filterOut(filterOut), .extRefOut(extRefOut), .autoRangeOut(autoRangeOut),
        .rangeCodeOut(rangeCodeOut), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    // free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stopTest();
        if (miscompares == 0 && testsRun > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ready is raised only once the answer shows, so the hold checks see a wait
    task automatic axiWrite(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
            if (bvalid) bready <= 1'b1;
        end
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axiRead(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
            if (rvalid) rready <= 1'b1;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // apply a command, let 3700 cycles pass, judge the decoded outputs
    task automatic runCase(input logic [11:0] c, input int f, input logic [3:0] code,
        input logic fl, input logic ex);
        cmdReq <= c;
        repeat (3700) @(posedge clk);
        check("function", 32'({lowOhmsOut, kiloResistOut, acVoltOut, dcVoltOut}),
            32'(4'h1 << f));
        check("range", 32'({autoRangeOut, rangeCodeOut}),
            32'({code == `RCS_RNG_AUTO, code[3:1]}));
        check("options", 32'({filterOut, extRefOut}), 32'({fl, ex}));
    endtask
    // capture one whole frame; option slots are left out, their sense is free
    task automatic serialFrame(input logic [7:0] exp);
        logic [7:0] cap;
        int gap;
        gap = 0;
        cap = 8'h00;
        for (int n = 0; n < 5000 && gap < 300; n++) begin
            @(posedge clk);
            gap = serialSlot ? 0 : gap + 1;
        end
        for (int j = 0; j < 8; j++) begin
            for (int n = 0; n < 500 && !serialSlot; n++) @(posedge clk);
            repeat (50) @(posedge clk);
            cap[j] = serialData;
            for (int n = 0; n < 500 && serialSlot; n++) @(posedge clk);
        end
        check("serial slots", 32'(cap & 8'hF3), 32'(exp));
    endtask
    task automatic pulseTrigger();
        trigReq <= 1'b1;
        @(posedge clk);
        trigReq <= 1'b0;
    endtask
    // triggered mode: hold until a pulse, a busy pulse is lost, software trigger
    task automatic triggered();
        logic [31:0] d, f0;
        logic [1:0] r;
        freeRun <= 1'b0;
        cmdReq <= 12'h024;
        repeat (3000) @(posedge clk);
        check("held output", 32'(kiloResistOut), 32'h0);
        axiRead(`RCS_STATUS_OFS, d, r);
        check("status", d, 32'h20);
        axiRead(`RCS_FRAMES_OFS, f0, r);
        pulseTrigger();
        repeat (300) @(posedge clk);
        pulseTrigger();
        repeat (2500) @(posedge clk);
        check("triggered output", 32'({kiloResistOut, rangeCodeOut}), 32'h9);
        axiRead(`RCS_FRAMES_OFS, d, r);
        check("one frame", d, f0 + 32'h1);
        axiWrite(`RCS_CTRL_OFS, 32'h3, r);
        check("ctrl write", 32'(r), 32'(RESP_OKAY));
        repeat (2000) @(posedge clk);
        axiRead(`RCS_FRAMES_OFS, d, r);
        check("soft frame", d, f0 + 32'h2);
    endtask
    // hang guard, well beyond the expected run
    initial begin
        repeat (90000) @(posedge clk);
        miscompares++;
        stopTest();
    end
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        rst_b <= 1'b0;
        cmdReq <= 12'h000;
        freeRun <= 1'b1;
        trigReq <= 1'b0;
        {awaddr, araddr, wdata} <= '0;
        wstrb <= 4'hF;
        {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        check("reset outputs", 32'({dcVoltOut, autoRangeOut, serialSlot}), 32'h6);
        axiRead(`RCS_CTRL_OFS, d, r);
        check("ctrl reset", d, 32'(`RCS_CTRL_RESET));
        axiRead(12'h010, d, r);
        check("unmapped read", 32'({r, d[7:0]}), 32'({RESP_SLVERR, 8'h00}));
        axiWrite(12'h010, 32'h0, r);
        check("unmapped write", 32'(r), 32'(RESP_SLVERR));
        runCase(12'h000, 0, `RCS_RNG_AUTO, 1'b0, 1'b0);
        runCase(12'h002, 1, `RCS_RNG_AUTO, 1'b0, 1'b0);
        runCase(12'h014, 2, `RCS_RNG_10K, 1'b0, 1'b0);
        runCase(12'h088, 3, `RCS_RNG_10, 1'b0, 1'b0);
        runCase(12'h011, 0, `RCS_RNG_AUTO, 1'b0, 1'b0);
        runCase(12'h601, 0, `RCS_RNG_0P1, 1'b1, 1'b0);
        runCase(12'h062, 1, `RCS_RNG_1K, 1'b0, 1'b0);
        runCase(12'h90E, 3, `RCS_RNG_AUTO, 1'b0, 1'b0);
        runCase(12'h202, 1, `RCS_RNG_AUTO, 1'b0, 1'b0);
        runCase(12'h844, 2, `RCS_RNG_100, 1'b0, 1'b0);
        runCase(12'h102, 1, `RCS_RNG_1, 1'b0, 1'b0);
        serialFrame(8'h91);
        runCase(12'h901, 0, `RCS_RNG_1, 1'b0, 1'b1);
        triggered();
        stopTest();
    end
endmodule // rcs_remote_command_serializer_tb
